// *** hdl/xlatc_pkg.sv ***
package xlatc_pkg;
    // register layout, 64-bit form
    localparam int REG_W = 64;
    localparam int MODE_LSB = 60;
    localparam int MODE_W = 4;
    localparam int TAG_LSB = 44;
    localparam int TAG_W_MAX = 16;
    localparam int TAG_W_MAX_32 = 9;
    localparam int ROOT_LSB = 0;
    localparam int ROOT_W = 44;
    localparam int PAGE_SHIFT = 12; // 4 KiB frames
    // implemented widths
    localparam int TAG_W_IMPL = 9;
    localparam int PHYS_ADDR_W = 56;
    localparam int ROOT_W_IMPL = PHYS_ADDR_W - PAGE_SHIFT;
    localparam logic [63:0] RESET_VALUE = 64'h0000000000000000;
    // scheme selector codes
    localparam logic [3:0] MODE_NONE = 4'h0;
    localparam logic [3:0] MODE_PAGING_32 = 4'h1;
    localparam logic [3:0] MODE_PAGING_39 = 4'h8;
    localparam logic [3:0] MODE_PAGING_48 = 4'h9;
    localparam logic [3:0] MODE_PAGING_57_RSVD = 4'hA;
    localparam logic [3:0] MODE_PAGING_64_RSVD = 4'hB;
    // fence instruction encoding
    localparam logic [6:0] OPC_SYSTEM = 7'h73;
    localparam logic [2:0] FUNCT3_PRIV = 3'h0;
    localparam logic [6:0] FUNCT7_FENCE = 7'h09;
    localparam logic [4:0] REG_ZERO = 5'h00;
    localparam int VPN_W = 36;
    // flush kinds
    typedef enum logic [1:0] {
        XLATC_FLUSH_ALL,
        XLATC_FLUSH_TAG,
        XLATC_FLUSH_ADDR,
        XLATC_FLUSH_ADDR_TAG
    } xlatc_flush_t;
endpackage

// *** hdl/xlatc_fence_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
// decodes a fence instruction into flush kind and operands
module xlatc_fence_decode
(
    input wire logic [31:0] instr,
    input wire logic [63:0] addr_value,
    input wire logic [63:0] tag_value,
    input wire logic simple_flush,
    output logic is_fence,
    output xlatc_pkg::xlatc_flush_t kind,
    output logic [xlatc_pkg::VPN_W-1:0] vpn,
    output logic [xlatc_pkg::TAG_W_IMPL-1:0] tag
);
    logic addr_zero;
    logic tag_zero;

    // system opcode, privileged funct3, zero destination
    assign is_fence = (instr[6:0] == xlatc_pkg::OPC_SYSTEM)
        && (instr[14:12] == xlatc_pkg::FUNCT3_PRIV)
        && (instr[11:7] == xlatc_pkg::REG_ZERO)
        && (instr[31:25] == xlatc_pkg::FUNCT7_FENCE);
    assign addr_zero = (instr[19:15] == xlatc_pkg::REG_ZERO);
    assign tag_zero = (instr[24:20] == xlatc_pkg::REG_ZERO);

    // register numbers pick the scope, not the values
    always_comb
    begin
        if (simple_flush)
            kind = xlatc_pkg::XLATC_FLUSH_ALL;
        else if (addr_zero && tag_zero)
            kind = xlatc_pkg::XLATC_FLUSH_ALL;
        else if (addr_zero)
            kind = xlatc_pkg::XLATC_FLUSH_TAG;
        else if (tag_zero)
            kind = xlatc_pkg::XLATC_FLUSH_ADDR;
        else
            kind = xlatc_pkg::XLATC_FLUSH_ADDR_TAG;
    end

    assign vpn = addr_value[xlatc_pkg::PAGE_SHIFT +: xlatc_pkg::VPN_W];
    // only implemented tag bits are used, upper bits ignored
    assign tag = tag_value[xlatc_pkg::TAG_W_IMPL-1:0];
endmodule
`default_nettype wire

// *** hdl/xlatc_top.sv ***
// Contract
// - root table stored as physical frame number, address divided by 4 KiB
// - 64-bit layout: selector 63:60, tag 59:44, root frame 43:0
// - selector 0 means no translation; other fields have no effect
// - 32-bit machines accept only selector 0 and 1
// - 64-bit selector: 8 and 9 paged, 10-11 held, others reserved
// - unsupported selector write is dropped entirely, register unchanged
// - frame bits beyond physical width are zero and read zero
// - tag width implementation-defined; low bits writable, rest read zero
// - tag width at most 9 for 32-bit, 16 for 39/48-bit paging
// - register write does not flush caches; software fences
// - fence orders earlier visible stores before later table accesses
// - fence invalidates affected local translation cache entries
// - fence acts only on this hart's own translation state
// - both sources zero register: flush everything including global
// - address zero, tag nonzero: flush all levels of that tag only
// - address nonzero, tag zero: flush the leaf for that address, all tags
// - both nonzero: flush the leaf for that address within that tag
// - tag source bits above implemented width are ignored
// - simple mode may ignore operands and flush globally
`timescale 1ns/1ns
`default_nettype none
module xlatc_top
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic simple_flush,
    input wire logic reg_wr_en,
    input wire logic [63:0] reg_wr_data,
    output logic [63:0] reg_rd_data,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [63:0] addr_value,
    input wire logic [63:0] tag_value,
    input wire logic stores_drained,
    output logic fence_ready,
    output logic fence_done,
    output logic flush_valid,
    input wire logic flush_ack,
    output logic [1:0] flush_kind,
    output logic [35:0] flush_vpn,
    output logic [8:0] flush_tag,
    output logic translate_en,
    output logic [3:0] mode_out,
    output logic [43:0] root_frame_out,
    output logic [8:0] tag_out
);
    typedef enum logic [1:0] {
        XLATC_IDLE,
        XLATC_DRAIN,
        XLATC_FLUSH
    } xlatc_state_t;

    logic [3:0] mode_reg;
    logic [xlatc_pkg::TAG_W_IMPL-1:0] tag_reg;
    logic [xlatc_pkg::ROOT_W_IMPL-1:0] root_reg;
    logic [3:0] wr_mode;
    logic wr_ok;
    logic is_fence;
    xlatc_pkg::xlatc_flush_t dec_kind;
    logic [xlatc_pkg::VPN_W-1:0] dec_vpn;
    logic [xlatc_pkg::TAG_W_IMPL-1:0] dec_tag;
    xlatc_state_t state_reg;
    xlatc_state_t state_next;
    logic [1:0] kind_reg;
    logic [35:0] vpn_reg;
    logic [8:0] ftag_reg;
    logic done_reg;

    // supported selector check, shared by write path
    function automatic logic mode_supported(input logic [3:0] m);
        case (m)
            xlatc_pkg::MODE_NONE: mode_supported = 1'b1;
            xlatc_pkg::MODE_PAGING_39: mode_supported = 1'b1;
            xlatc_pkg::MODE_PAGING_48: mode_supported = 1'b1;
            default: mode_supported = 1'b0;
        endcase
    endfunction

    assign wr_mode = reg_wr_data[xlatc_pkg::MODE_LSB +: xlatc_pkg::MODE_W];
    assign wr_ok = mode_supported(wr_mode);

    // control register update, whole write dropped on bad selector
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mode_reg <= xlatc_pkg::RESET_VALUE[63:60];
            tag_reg <= '0;
            root_reg <= '0;
        end
        else if (reg_wr_en && wr_ok)
        begin
            mode_reg <= wr_mode;
            tag_reg <= reg_wr_data[xlatc_pkg::TAG_LSB +: xlatc_pkg::TAG_W_IMPL];
            root_reg <= reg_wr_data[xlatc_pkg::ROOT_LSB +: xlatc_pkg::ROOT_W_IMPL];
        end
    end

    // read back, unimplemented bits zero
    always_comb
    begin
        reg_rd_data = '0;
        reg_rd_data[xlatc_pkg::MODE_LSB +: xlatc_pkg::MODE_W] = mode_reg;
        reg_rd_data[xlatc_pkg::TAG_LSB +: xlatc_pkg::TAG_W_IMPL] = tag_reg;
        reg_rd_data[xlatc_pkg::ROOT_LSB +: xlatc_pkg::ROOT_W_IMPL] = root_reg;
    end

    // state to the local translation hardware; writes alone never flush
    assign translate_en = (mode_reg != xlatc_pkg::MODE_NONE);
    assign mode_out = mode_reg;
    // frame bits above the physical width stay zero
    assign root_frame_out = xlatc_pkg::ROOT_W'(root_reg);
    assign tag_out = tag_reg;

    xlatc_fence_decode u_dec
    (
        .instr(instr),
        .addr_value(addr_value),
        .tag_value(tag_value),
        .simple_flush(simple_flush),
        .is_fence(is_fence),
        .kind(dec_kind),
        .vpn(dec_vpn),
        .tag(dec_tag)
    );

    // fence sequencer: drain stores, then flush local caches
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            XLATC_IDLE:
                if (instr_valid && is_fence)
                    state_next = XLATC_DRAIN;
            XLATC_DRAIN:
                if (stores_drained)
                    state_next = XLATC_FLUSH;
            XLATC_FLUSH:
                if (flush_ack)
                    state_next = XLATC_IDLE;
            default:
                state_next = XLATC_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_reg <= XLATC_IDLE;
        else
            state_reg <= state_next;
    end

    // capture fence operands when accepted
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            kind_reg <= 2'h0;
            vpn_reg <= 36'h000000000;
            ftag_reg <= 9'h000;
        end
        else if (state_reg == XLATC_IDLE && instr_valid && is_fence)
        begin
            kind_reg <= dec_kind;
            vpn_reg <= dec_vpn;
            ftag_reg <= dec_tag;
        end
    end

    // completion pulse after local flush only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            done_reg <= 1'b0;
        else
            done_reg <= (state_reg == XLATC_FLUSH) && flush_ack;
    end

    assign fence_ready = (state_reg == XLATC_IDLE);
    assign flush_valid = (state_reg == XLATC_FLUSH);
    assign flush_kind = kind_reg;
    assign flush_vpn = vpn_reg;
    assign flush_tag = ftag_reg;
    assign fence_done = done_reg;
endmodule
`default_nettype wire

// *** testbench/xlatc_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module xlatc_properties
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic simple_flush,
    input wire logic reg_wr_en,
    input wire logic [63:0] reg_wr_data,
    input wire logic [63:0] reg_rd_data,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [63:0] addr_value,
    input wire logic [63:0] tag_value,
    input wire logic stores_drained,
    input wire logic fence_ready,
    input wire logic fence_done,
    input wire logic flush_valid,
    input wire logic flush_ack,
    input wire logic [1:0] flush_kind,
    input wire logic [35:0] flush_vpn,
    input wire logic [8:0] flush_tag,
    input wire logic translate_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic ok_mode;
    // accepted fence and supported selector
    assign take = instr_valid && fence_ready && instr[31:25] == 7'h09 && instr[14:0] == 15'h0073;
    assign ok_mode = reg_wr_data[63:60] inside {4'h0, 4'h8, 4'h9};
    property p_transl; translate_en == (reg_rd_data[63:60] != 4'h0); endproperty
    a_transl: assert property (p_transl) else $error("translate enable wrong");
    property p_take; reg_wr_en && ok_mode |=> reg_rd_data[63:60] == $past(reg_wr_data[63:60]); endproperty
    a_take: assert property (p_take) else $error("write not taken");
    property p_drop; reg_wr_en && !ok_mode |=> $stable(reg_rd_data); endproperty
    a_drop: assert property (p_drop) else $error("bad selector changed register");
    property p_fence; take |=> !fence_ready; endproperty
    a_fence: assert property (p_fence) else $error("fence not taken");
    property p_drain; !stores_drained && !fence_ready && !flush_valid |=> !flush_valid; endproperty
    a_drain: assert property (p_drain) else $error("flush before stores drained");
    property p_done; flush_valid && flush_ack |=> fence_done && fence_ready ##1 !fence_done; endproperty
    a_done: assert property (p_done) else $error("fence completion wrong");
    property p_kind; take && !simple_flush |=>
        flush_kind == {$past(instr[19:15]) != 5'h00, $past(instr[24:20]) != 5'h00}; endproperty
    a_kind: assert property (p_kind) else $error("flush kind wrong");
    property p_opnd; take |=> flush_vpn == $past(addr_value[47:12]) && flush_tag == $past(tag_value[8:0]);
    endproperty
    a_opnd: assert property (p_opnd) else $error("flush operands wrong");
    // main scenarios
    c_all: cover property (take && instr[24:15] == 10'h000);
    c_leaf: cover property (take && instr[19:15] != 5'h00 && instr[24:20] != 5'h00);
    c_drop: cover property (reg_wr_en && !ok_mode);
endmodule
bind xlatc_top xlatc_properties chk (.clk, .rst_n, .simple_flush, .reg_wr_en, .reg_wr_data,
    .reg_rd_data, .instr_valid, .instr, .addr_value, .tag_value, .stores_drained, .fence_ready,
    .fence_done, .flush_valid, .flush_ack, .flush_kind, .flush_vpn, .flush_tag, .translate_en);
`default_nettype wire

// *** testbench/xlatc_pipe_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module xlatc_pipe_model
(
    input wire logic clk,
    input wire logic slow,
    input wire logic fence_ready,
    input wire logic flush_valid,
    output logic stores_drained = 1'b0,
    output logic flush_ack = 1'b0
);
    int cnt = 0;
    // drain and cache answers, prompt or delayed
    always @(negedge clk)
    begin
        cnt = fence_ready ? 0 : cnt + 1;
        stores_drained <= !slow || cnt > 2;
        flush_ack <= flush_valid && (!slow || cnt > 5);
    end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk, rst_n, simple_flush, reg_wr_en, instr_valid, slow, stores_drained;
    logic fence_ready, fence_done, flush_valid, flush_ack, translate_en;
    logic [63:0] reg_wr_data, reg_rd_data, addr_value, tag_value;
    logic [31:0] instr;
    logic [1:0] flush_kind;
    logic [35:0] flush_vpn;
    logic [8:0] flush_tag, tag_out;
    logic [3:0] mode_out;
    logic [43:0] root_frame_out;
    int err_total = 0;
    int num_checks = 0;
    xlatc_top dut (.clk(clk), .rst_n(rst_n), .simple_flush(simple_flush), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .instr_valid(instr_valid),
        .instr(instr), .addr_value(addr_value), .tag_value(tag_value),
        .stores_drained(stores_drained), .fence_ready(fence_ready), .fence_done(fence_done),
        .flush_valid(flush_valid), .flush_ack(flush_ack), .flush_kind(flush_kind),
        .flush_vpn(flush_vpn), .flush_tag(flush_tag), .translate_en(translate_en),
        .mode_out(mode_out), .root_frame_out(root_frame_out), .tag_out(tag_out));
    xlatc_pipe_model partner (.clk(clk), .slow(slow), .fence_ready(fence_ready),
        .flush_valid(flush_valid), .stores_drained(stores_drained), .flush_ack(flush_ack));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task final_report;
        if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task wr(input logic [63:0] d);
        reg_wr_en = 1'b1;
        reg_wr_data = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
    endtask
    task t_regs;
        chk("reset", 64'h0, reg_rd_data);
        wr(64'h8FFF_FFFF_FFFF_FFFF);
        chk("tag_width", 64'h801F_FFFF_FFFF_FFFF, reg_rd_data);
        chk("no_flush", 64'h0, {63'h0, flush_valid});
        for (int m = 1; m < 16; m++)
            if (m != 8 && m != 9)
            begin
                wr({m[3:0], 60'hFFF_FFFF_FFFF_FFFF});
                chk("dropped", 64'h801F_FFFF_FFFF_FFFF, reg_rd_data);
            end
        wr(64'h9000_0000_0000_0123);
        chk("mode9", 64'h9000_0000_0000_0123, reg_rd_data);
        chk("root", 64'h123, {20'h0, root_frame_out});
        chk("xlat_on", 64'h1, {63'h0, translate_en});
        wr(64'h0);
        chk("xlat_off", 64'h0, {63'h0, translate_en});
    endtask
    task fence(input logic [4:0] r1, input logic [4:0] r2, input logic [1:0] k, input logic s);
        int n;
        simple_flush = s;
        slow = k[0];
        instr = {7'h09, r2, r1, 8'h00, 7'h73};
        addr_value = 64'hFFFF_1234_5678_9ABC;
        tag_value = 64'hFFFF_FFFF_FFFF_FE5A;
        instr_valid = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
        chk("busy", 64'h0, {63'h0, fence_ready});
        for (n = 0; n < 20 && flush_valid !== 1'b1; n++) @(negedge clk);
        if (n == 20)
        begin
            err_total++;
            final_report;
        end
        chk("kind", {62'h0, k}, {62'h0, flush_kind});
        chk("vpn", 64'h1_2345_6789, {28'h0, flush_vpn});
        chk("tag", 64'h5A, {55'h0, flush_tag});
        for (n = 0; n < 20 && fence_done !== 1'b1; n++) @(negedge clk);
        if (n == 20)
        begin
            err_total++;
            final_report;
        end
        @(negedge clk);
    endtask
    task t_fences;
        for (int k = 0; k < 4; k++)
            fence(k[1] ? 5'h05 : 5'h00, k[0] ? 5'h06 : 5'h00, k[1:0], 1'b0);
    endtask
    task t_simple;
        fence(5'h05, 5'h06, 2'h0, 1'b1);
        simple_flush = 1'b0;
    endtask
    task t_refuse;
        instr = {7'h09, 5'h06, 5'h05, 3'h0, 5'h01, 7'h73};
        instr_valid = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
        chk("refused", 64'h1, {63'h0, fence_ready});
    endtask
    initial
    begin
        rst_n = 1'b0;
        {simple_flush, reg_wr_en, instr_valid, slow} = 4'h0;
        {reg_wr_data, addr_value, tag_value, instr} = '0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_regs;
        t_fences;
        t_simple;
        t_refuse;
        final_report;
    end
endmodule
`default_nettype wire
